// File: design/asfr_flag_reg.sv
// ALU with its arithmetic status flag register and a plain register port.
// Assumes all inputs come from logic on core_clk and that the core decodes the operation.
`timescale 1ns/1ps
module asfr_flag_reg
  import asfr_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  // Register port.
  input  wire logic [ASFR_ADDR_W-1:0] reg_addr,
  input  wire logic [ASFR_DATA_W-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [ASFR_DATA_W-1:0] reg_rdata,
  // Operation port.
  input  wire logic                   op_valid,
  input  wire asfr_op_t               op_code,
  input  wire logic [ASFR_DATA_W-1:0] op_file,
  input  wire logic [ASFR_DATA_W-1:0] op_work,
  input  wire logic [2:0]             op_bit,
  input  wire logic                   op_src_flag,
  input  wire logic                   op_dst_flag,
  // Results.
  output logic      [ASFR_DATA_W-1:0] result_q,
  output logic                        result_wr_q,
  output logic      [ASFR_FLAG_W-1:0] flag_q
);

  // --------------------------------------------------------------------------
  // Operand selection
  // --------------------------------------------------------------------------
  logic [ASFR_DATA_W-1:0] opa;
  logic [ASFR_DATA_W-1:0] addb;
  logic                   addc_in;
  logic [ASFR_DATA_W:0]   sum9;
  logic [4:0]             nib5;
  logic [ASFR_DATA_W-1:0] res;
  logic [ASFR_FLAG_W-1:0] mask;
  logic [ASFR_FLAG_W-1:0] new_flags;
  logic [ASFR_FLAG_W-1:0] flag_d;
  logic [ASFR_DATA_W-1:0] bit_one;
  logic                   flag_hit_wr;
  logic                   flag_hit_rd;
  logic                   op_neutral;

  assign opa         = op_src_flag ? {3'h0, flag_q} : op_file;
  assign bit_one     = 8'h01 << op_bit;
  assign flag_hit_wr = reg_wr && (reg_addr == ASFR_FLAG_ADDR);
  assign flag_hit_rd = reg_rd && (reg_addr == ASFR_FLAG_ADDR);

  // --------------------------------------------------------------------------
  // Adder inputs
  // --------------------------------------------------------------------------
  always_comb begin
    addb    = op_work;
    addc_in = 1'b0;
    case (op_code)
      ASFR_OP_ADD: begin
        addb    = op_work;
        addc_in = 1'b0;
      end
      ASFR_OP_ADDC: begin
        addb    = op_work;
        addc_in = flag_q[ASFR_BIT_CARRY];
      end
      ASFR_OP_SUB: begin
        addb    = ~op_work;
        addc_in = 1'b1;
      end
      ASFR_OP_INC: begin
        addb    = 8'h00;
        addc_in = 1'b1;
      end
      ASFR_OP_DEC: begin
        addb    = 8'hff;
        addc_in = 1'b0;
      end
      default: begin
        addb    = op_work;
        addc_in = 1'b0;
      end
    endcase
  end

  assign sum9 = {1'b0, opa} + {1'b0, addb} + {8'h00, addc_in};
  assign nib5 = {1'b0, opa[3:0]} + {1'b0, addb[3:0]} + {4'h0, addc_in};

  // --------------------------------------------------------------------------
  // Result and affected flags
  // --------------------------------------------------------------------------
  always_comb begin
    res  = sum9[ASFR_DATA_W-1:0];
    mask = ASFR_MASK_NONE;
    case (op_code)
      ASFR_OP_ADD, ASFR_OP_ADDC, ASFR_OP_SUB, ASFR_OP_INC, ASFR_OP_DEC: begin
        res  = sum9[ASFR_DATA_W-1:0];
        mask = ASFR_MASK_ALL;
      end
      ASFR_OP_AND: begin
        res  = opa & op_work;
        mask = ASFR_MASK_ZN;
      end
      ASFR_OP_OR: begin
        res  = opa | op_work;
        mask = ASFR_MASK_ZN;
      end
      ASFR_OP_XOR: begin
        res  = opa ^ op_work;
        mask = ASFR_MASK_ZN;
      end
      ASFR_OP_COMP: begin
        res  = ~opa;
        mask = ASFR_MASK_ZN;
      end
      ASFR_OP_FILE_CLEAR: begin
        res  = 8'h00;
        mask = ASFR_MASK_Z;
      end
      ASFR_OP_BIT_CLEAR: begin
        res  = opa & ~bit_one;
        mask = ASFR_MASK_NONE;
      end
      ASFR_OP_BIT_SET: begin
        res  = opa | bit_one;
        mask = ASFR_MASK_NONE;
      end
      ASFR_OP_NIBBLE_SWAP: begin
        res  = {opa[3:0], opa[7:4]};
        mask = ASFR_MASK_NONE;
      end
      ASFR_OP_FILE_TO_FILE_MOVE: begin
        res  = opa;
        mask = ASFR_MASK_NONE;
      end
      ASFR_OP_W_TO_FILE_MOVE: begin
        res  = op_work;
        mask = ASFR_MASK_NONE;
      end
      default: begin
        res  = opa;
        mask = ASFR_MASK_NONE;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Destination decode
  // --------------------------------------------------------------------------
  assign op_neutral = (mask == ASFR_MASK_NONE);

  // --------------------------------------------------------------------------
  // Flag values computed by the operation
  // --------------------------------------------------------------------------
  always_comb begin
    new_flags                  = ASFR_FLAG_RESET;
    new_flags[ASFR_BIT_CARRY]  = sum9[ASFR_DATA_W];
    new_flags[ASFR_BIT_NIBBLE] = nib5[4];
    new_flags[ASFR_BIT_ZERO]   = (res == 8'h00);
    new_flags[ASFR_BIT_WRAP]   = (opa[7] == addb[7]) && (res[7] != opa[7]);
    new_flags[ASFR_BIT_MSB]    = res[7];
  end

  // --------------------------------------------------------------------------
  // Flag register next value
  // --------------------------------------------------------------------------
  always_comb begin
    flag_d = flag_q;
    if (flag_hit_wr) begin
      flag_d = reg_wdata[ASFR_FLAG_W-1:0];
    end
    if (op_valid) begin
      if (op_dst_flag && op_neutral) begin
        flag_d = res[ASFR_FLAG_W-1:0];
      end
      flag_d = (flag_d & ~mask) | (new_flags & mask);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= ASFR_FLAG_RESET;
    end else begin
      flag_q <= flag_d;
    end
  end

  // --------------------------------------------------------------------------
  // Result output
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= ASFR_RES_RESET;
    end else if (op_valid) begin
      result_q <= res;
    end
  end

  // --------------------------------------------------------------------------
  // Result write strobe
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_wr_q <= 1'b0;
    end else begin
      result_wr_q <= op_valid && !op_dst_flag;
    end
  end

  // --------------------------------------------------------------------------
  // Register read port
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= ASFR_RD_IDLE;
    end else if (flag_hit_rd) begin
      reg_rdata <= {3'h0, flag_q};
    end else begin
      reg_rdata <= ASFR_RD_IDLE;
    end
  end

endmodule // asfr_flag_reg

// File: design/asfr_pkg.sv
// Constants, operation codes and flag layout of the ALU status flag register.
// Assumes a single core clock domain and a core that hands one decoded operation per cycle.
// ----------------------------------------------------------------------------
// What this block does
// ----------------------------------------------------------------------------
// What this block does
// - The flag register can be read as a source operand and written as a destination.
// - A flag-changing operation aimed at the flag register stores only its flag updates.
// - Clearing the flag register sets only the zero flag and keeps the other flags.
// - Bit clear, bit set, nibble swap and both moves keep flags and write the result normally.
// - In subtraction the carry and nibble carry flags mean no borrow and no digit borrow.
// - The negative flag copies the most significant bit of the result.
// - The signed overflow flag is set when the sign bit changes by overflow, else cleared.
package asfr_pkg;

  // --------------------------------------------------------------------------
  // Register map and flag layout
  // --------------------------------------------------------------------------
  localparam int         ASFR_ADDR_W     = 8;
  localparam int         ASFR_DATA_W     = 8;
  localparam int         ASFR_FLAG_W     = 5;
  localparam logic [7:0] ASFR_FLAG_ADDR  = 8'h00;
  localparam int         ASFR_BIT_CARRY  = 0;
  localparam int         ASFR_BIT_NIBBLE = 1;
  localparam int         ASFR_BIT_ZERO   = 2;
  localparam int         ASFR_BIT_WRAP   = 3;
  localparam int         ASFR_BIT_MSB    = 4;
  localparam logic [4:0] ASFR_FLAG_RESET = 5'h00;
  localparam logic [7:0] ASFR_RES_RESET  = 8'h00;
  localparam logic [7:0] ASFR_RD_IDLE    = 8'h00;

  // --------------------------------------------------------------------------
  // Affected-flag masks
  // --------------------------------------------------------------------------
  localparam logic [4:0] ASFR_MASK_ALL   = 5'h1f;
  localparam logic [4:0] ASFR_MASK_ZN    = 5'h14;
  localparam logic [4:0] ASFR_MASK_Z     = 5'h04;
  localparam logic [4:0] ASFR_MASK_NONE  = 5'h00;

  // --------------------------------------------------------------------------
  // Operations
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    ASFR_OP_ADD,
    ASFR_OP_ADDC,
    ASFR_OP_SUB,
    ASFR_OP_INC,
    ASFR_OP_DEC,
    ASFR_OP_AND,
    ASFR_OP_OR,
    ASFR_OP_XOR,
    ASFR_OP_COMP,
    ASFR_OP_FILE_CLEAR,
    ASFR_OP_BIT_CLEAR,
    ASFR_OP_BIT_SET,
    ASFR_OP_NIBBLE_SWAP,
    ASFR_OP_FILE_TO_FILE_MOVE,
    ASFR_OP_W_TO_FILE_MOVE
  } asfr_op_t;

endpackage : asfr_pkg

// File: tb/asfr_flag_reg_checker.sv
// Assertions on the ports of the ALU status flag register.
// Assumes one core clock and the asynchronous active-low reset.
`timescale 1ns/1ps
module asfr_flag_reg_checker
  import asfr_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       op_valid,
  input wire asfr_op_t   op_code,
  input wire logic [7:0] op_file,
  input wire logic [7:0] op_work,
  input wire logic       op_src_flag,
  input wire logic       op_dst_flag,
  input wire logic [7:0] result_q,
  input wire logic       result_wr_q,
  input wire logic [4:0] flag_q
);
  // --------------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_rd; reg_rd && reg_addr == ASFR_FLAG_ADDR |=> reg_rdata == {3'h0, $past(flag_q)};
  endproperty
  a_rd: assert property (p_rd) else $error("flag read wrong");
  property p_rd0; !(reg_rd && reg_addr == ASFR_FLAG_ADDR) |=> reg_rdata == 8'h00; endproperty
  a_rd0: assert property (p_rd0) else $error("idle read data not zero");
  property p_wr; reg_wr && reg_addr == ASFR_FLAG_ADDR && !op_valid
    |=> flag_q == $past(reg_wdata[4:0]); endproperty
  a_wr: assert property (p_wr) else $error("flag write lost");
  property p_dst; op_valid |=> result_wr_q == !$past(op_dst_flag); endproperty
  a_dst: assert property (p_dst) else $error("result write strobe wrong");
  property p_clr; op_valid && op_dst_flag && op_code == ASFR_OP_FILE_CLEAR && !reg_wr
    |=> flag_q == ($past(flag_q) | ASFR_MASK_Z); endproperty
  a_clr: assert property (p_clr) else $error("clear of flags wrong");
  property p_neu; op_valid && !op_dst_flag && op_code >= ASFR_OP_BIT_CLEAR && !reg_wr
    |=> $stable(flag_q); endproperty
  a_neu: assert property (p_neu) else $error("neutral op changed flags");
  property p_msb; op_valid && !op_dst_flag && op_code <= ASFR_OP_COMP
    |=> flag_q[ASFR_BIT_MSB] == result_q[7]; endproperty
  a_msb: assert property (p_msb) else $error("negative flag wrong");
  property p_ov; op_valid && !op_dst_flag && !op_src_flag && op_code == ASFR_OP_ADD
    |=> flag_q[ASFR_BIT_WRAP] == ($past(op_file[7]) == $past(op_work[7])
    && result_q[7] != $past(op_file[7])); endproperty
  a_ov: assert property (p_ov) else $error("overflow flag wrong");
  property p_z; op_valid && !op_dst_flag && op_code <= ASFR_OP_COMP
    |=> flag_q[ASFR_BIT_ZERO] == (result_q == 8'h00); endproperty
  a_z: assert property (p_z) else $error("zero flag wrong");
endmodule // asfr_flag_reg_checker
bind asfr_flag_reg asfr_flag_reg_checker u_asfr_flag_reg_checker (
  .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_valid(op_valid),
  .op_code(op_code), .op_file(op_file), .op_work(op_work), .op_src_flag(op_src_flag),
  .op_dst_flag(op_dst_flag), .result_q(result_q), .result_wr_q(result_wr_q), .flag_q(flag_q));

// File: tb/test_asfr_flag_reg.sv
// Testbench for the ALU status flag register: bus and operation sequences.
// Assumes the package and design under design/ are compiled first.
`timescale 1ns/1ps
module test_asfr_flag_reg;
  import asfr_pkg::*;
  logic       core_clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic       op_valid = 1'h0, op_src_flag = 1'h0, op_dst_flag = 1'h0, result_wr_q;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, op_file = 8'h00, op_work = 8'h00;
  logic [7:0] reg_rdata, result_q;
  logic [2:0] op_bit = 3'h0;
  logic [4:0] flag_q;
  asfr_op_t   op_code = ASFR_OP_ADD;
  int         num_errors = 0, n_checks = 0;
  asfr_flag_reg u_asfr_flag_reg (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .op_valid(op_valid), .op_code(op_code), .op_file(op_file), .op_work(op_work),
    .op_bit(op_bit), .op_src_flag(op_src_flag), .op_dst_flag(op_dst_flag),
    .result_q(result_q), .result_wr_q(result_wr_q), .flag_q(flag_q));
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic opc(input asfr_op_t c, input logic [7:0] f, input logic [7:0] w,
                     input logic [2:0] b, input logic s, input logic d,
                     input logic [4:0] ef, input logic ew);
    @(posedge core_clk);
    op_valid <= 1'h1;
    op_code <= c;
    op_file <= f;
    op_work <= w;
    op_bit <= b;
    op_src_flag <= s;
    op_dst_flag <= d;
    @(posedge core_clk);
    op_valid <= 1'h0;
    #1 chk({3'h0, flag_q}, {3'h0, ef});
    chk({7'h00, result_wr_q}, {7'h00, ew});
  endtask
  task automatic results;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // --------------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'h1;
    rd(8'h00, 8'h00);
    wr(8'h05, 8'h1f);
    rd(8'h05, 8'h00);
    rd(8'h00, 8'h00);
    wr(8'h00, 8'hff);
    rd(8'h00, 8'h1f);
    wr(8'h00, 8'h0b);
    opc(ASFR_OP_FILE_CLEAR, 8'h00, 8'h00, 3'h0, 1'h1, 1'h1, 5'h0f, 1'h0);
    opc(ASFR_OP_ADD, 8'h7f, 8'h01, 3'h0, 1'h0, 1'h0, 5'h1a, 1'h1);
    chk(result_q, 8'h80);
    opc(ASFR_OP_ADD, 8'hff, 8'h01, 3'h0, 1'h0, 1'h1, 5'h07, 1'h0);
    opc(ASFR_OP_ADD, 8'h80, 8'h80, 3'h0, 1'h0, 1'h0, 5'h0d, 1'h1);
    opc(ASFR_OP_SUB, 8'h05, 8'h03, 3'h0, 1'h0, 1'h0, 5'h03, 1'h1);
    opc(ASFR_OP_SUB, 8'h03, 8'h05, 3'h0, 1'h0, 1'h0, 5'h10, 1'h1);
    opc(ASFR_OP_AND, 8'hff, 8'h00, 3'h0, 1'h0, 1'h0, 5'h04, 1'h1);
    for (int i = 0; i < 5; i++) begin
      opc(asfr_op_t'(ASFR_OP_BIT_CLEAR + i), 8'h00, 8'h00, 3'h0, 1'h0, 1'h0, 5'h04, 1'h1);
    end
    opc(ASFR_OP_BIT_SET, 8'h00, 8'h00, 3'h3, 1'h1, 1'h1, 5'h0c, 1'h0);
    opc(ASFR_OP_W_TO_FILE_MOVE, 8'h00, 8'h15, 3'h0, 1'h0, 1'h1, 5'h15, 1'h0);
    rd(8'h00, 8'h15);
    opc(ASFR_OP_NIBBLE_SWAP, 8'h00, 8'h00, 3'h0, 1'h1, 1'h1, 5'h11, 1'h0);
    opc(ASFR_OP_FILE_TO_FILE_MOVE, 8'he3, 8'h00, 3'h0, 1'h0, 1'h1, 5'h03, 1'h0);
    opc(ASFR_OP_ADDC, 8'h10, 8'h20, 3'h0, 1'h0, 1'h0, 5'h00, 1'h1);
    chk(result_q, 8'h31);
    opc(ASFR_OP_SUB, 8'h10, 8'h01, 3'h0, 1'h0, 1'h0, 5'h01, 1'h1);
    chk(result_q, 8'h0f);
    opc(ASFR_OP_DEC, 8'h80, 8'h00, 3'h0, 1'h0, 1'h0, 5'h09, 1'h1);
    chk(result_q, 8'h7f);
    opc(ASFR_OP_INC, 8'hff, 8'h00, 3'h0, 1'h0, 1'h0, 5'h07, 1'h1);
    opc(ASFR_OP_OR, 8'h80, 8'h01, 3'h0, 1'h0, 1'h0, 5'h13, 1'h1);
    chk(result_q, 8'h81);
    opc(ASFR_OP_XOR, 8'h5a, 8'h5a, 3'h0, 1'h0, 1'h0, 5'h07, 1'h1);
    opc(ASFR_OP_COMP, 8'h7f, 8'h00, 3'h0, 1'h0, 1'h0, 5'h13, 1'h1);
    chk(result_q, 8'h80);
    opc(ASFR_OP_BIT_CLEAR, 8'hff, 8'h00, 3'h7, 1'h0, 1'h0, 5'h13, 1'h1);
    chk(result_q, 8'h7f);
    rd(8'h00, 8'h13);
    results();
  end
endmodule // test_asfr_flag_reg
